/* include/fapc_pkg.sv */
/*
 Constants for the fast ADC peak/pit capture control block.
 Assumes one 40 MHz clock and a host on a byte strobe port.
*/
package fapc_pkg;
   // ---------------------------------------------
   // Control word fields
   // ---------------------------------------------
   localparam int CW_RUN = 0;
   localparam int CW_ARM = 1;
   localparam int CW_GAIN = 2;
   localparam int CW_VEDGE = 3;
   localparam int CW_SMODE_N = 4;
   localparam int CW_RAMWE_N = 5;
   localparam int CW_ALOAD_N = 6;
   localparam int CW_PLOAD_N = 7;
   localparam int CW_VTEN_N = 8;
   localparam int CW_RDCLK_N = 9;
   localparam int CW_PIT = 15;
   localparam logic [15:0] CW_RESET = 16'h03F0;
   // ---------------------------------------------
   // Port locations and sizes
   // ---------------------------------------------
   localparam logic SEL_PRIMARY = 1'b0;
   localparam logic SEL_SECONDARY = 1'b1;
   localparam int ADDR_W = 15;
   localparam int RAM_DEPTH = 32768;
   localparam int FULL_RATE_MHZ = 12;
endpackage : fapc_pkg

/* rtl/fapc_capture.sv */
/*
 Fast ADC capture control: hold latch with peak/pit/sample
 detection, sample RAM, control word and host byte port.
 Assumes all inputs synchronous to ref_clk; sample_tick is a
 one-cycle write-clock enable from an outside clock generator.
*/
`timescale 1ns/1ps
`default_nettype none
module fapc_capture (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [7:0] adc_data,
   input wire logic sample_tick,
   input wire logic bucket_start_clock,
   input wire logic full_rate_select,
   input wire logic sweep_trigger_line,
   input wire logic video_trigger_in,
   input wire logic port_select_line,
   input wire logic high_byte_strobe,
   input wire logic low_byte_strobe,
   input wire logic [7:0] host_data_in,
   output logic [7:0] host_data_out,
   output logic host_data_oe,
   output logic hold_load_n,
   output logic input_below_held,
   output logic input_above_held,
   output logic [7:0] held_byte,
   output logic capture_run,
   output logic trigger_fired,
   output logic double_gain_on,
   output logic video_edge_select,
   output logic video_trigger_enable_n,
   output logic sample_mode_n,
   output logic ram_write_enable_n,
   output logic addr_counter_load_n,
   output logic post_counter_load_n,
   output logic read_clock_enable_n,
   output logic pit_select,
   output logic [15:0] capture_control_word,
   output logic [15:0] post_count_value,
   output logic [14:0] ram_addr
);
   // ---------------------------------------------
   // Storage
   // ---------------------------------------------
   logic [15:0] cw_r, cw_nxt;
   logic [7:0] hi_r, hi_nxt;
   logic [7:0] held_r, held_nxt;
   logic [14:0] addr_r, addr_nxt;
   logic [15:0] post_r, post_nxt;
   logic [7:0] rd_r, rd_nxt;
   logic hs_q_r, ls_q_r;
   logic fired_r, fired_nxt;
   logic [7:0] ram [fapc_pkg::RAM_DEPTH];
   logic ram_we;
   logic [14:0] ram_wa;
   logic hs_rise, ls_rise, any_fall, sec_read, rd_clk_on;

   function automatic logic [1:0] cmp8(input logic [7:0] p, input logic [7:0] q);
      cmp8 = {p < q, p > q};
   endfunction : cmp8

   // ---------------------------------------------
   // Control word decode
   // ---------------------------------------------
   assign capture_control_word = cw_r;
   assign capture_run = cw_r[fapc_pkg::CW_RUN];
   assign double_gain_on = cw_r[fapc_pkg::CW_GAIN];
   assign video_edge_select = cw_r[fapc_pkg::CW_VEDGE];
   assign video_trigger_enable_n = cw_r[fapc_pkg::CW_VTEN_N];
   assign sample_mode_n = cw_r[fapc_pkg::CW_SMODE_N];
   assign ram_write_enable_n = cw_r[fapc_pkg::CW_RAMWE_N];
   assign addr_counter_load_n = cw_r[fapc_pkg::CW_ALOAD_N];
   assign post_counter_load_n = cw_r[fapc_pkg::CW_PLOAD_N];
   assign read_clock_enable_n = cw_r[fapc_pkg::CW_RDCLK_N];
   assign pit_select = cw_r[fapc_pkg::CW_PIT];
   assign held_byte = held_r;
   assign ram_addr = addr_r;
   assign post_count_value = post_r;
   assign trigger_fired = fired_r;
   assign {input_below_held, input_above_held} = cmp8(adc_data, held_r);

   // ---------------------------------------------
   // Hold latch load enable
   // ---------------------------------------------
   always_comb begin
      if (full_rate_select) begin
         hold_load_n = 1'b0;
      end else if (!sample_mode_n) begin
         hold_load_n = 1'b0;
      end else if (bucket_start_clock) begin
         hold_load_n = 1'b0;
      end else if (pit_select) begin
         hold_load_n = !input_below_held;
      end else begin
         hold_load_n = !input_above_held;
      end
   end

   // ---------------------------------------------
   // Host port
   // ---------------------------------------------
   assign hs_rise = high_byte_strobe && !hs_q_r;
   assign ls_rise = low_byte_strobe && !ls_q_r;
   assign any_fall = (hs_q_r && !high_byte_strobe) || (ls_q_r && !low_byte_strobe);
   // Read direction only with capture stopped and no load enabled
   assign sec_read = !capture_run && addr_counter_load_n && post_counter_load_n;
   assign rd_clk_on = !read_clock_enable_n && !capture_run;
   assign host_data_out = rd_r;
   assign host_data_oe = port_select_line && sec_read && (high_byte_strobe || low_byte_strobe);

   // ---------------------------------------------
   // Next state
   // ---------------------------------------------
   always_comb begin
      cw_nxt = cw_r;
      hi_nxt = hi_r;
      held_nxt = held_r;
      addr_nxt = addr_r;
      post_nxt = post_r;
      fired_nxt = fired_r;
      ram_we = 1'b0;
      ram_wa = addr_r;
      if (hs_rise && !(port_select_line && sec_read)) begin
         hi_nxt = host_data_in;
      end
      if (ls_rise && port_select_line == fapc_pkg::SEL_PRIMARY) begin
         cw_nxt = {hi_r, host_data_in};
      end
      if (ls_rise && port_select_line == fapc_pkg::SEL_SECONDARY && !sec_read && rd_clk_on) begin
         if (!addr_counter_load_n) begin
            addr_nxt = {hi_r[6:0], host_data_in};
         end
         if (!post_counter_load_n) begin
            post_nxt = {hi_r, host_data_in};
         end
      end
      if (any_fall && port_select_line && sec_read && rd_clk_on) begin
         addr_nxt = addr_r + 15'h0001;
      end
      if (capture_run && sample_tick) begin
         if (!hold_load_n) begin
            held_nxt = adc_data;
         end
         if (full_rate_select || bucket_start_clock) begin
            ram_wa = addr_r + 15'h0001;
         end
         addr_nxt = ram_wa;
         ram_we = !ram_write_enable_n;
      end
      if (!cw_r[fapc_pkg::CW_ARM]) begin
         fired_nxt = 1'b0;
      end else if (capture_run && (sweep_trigger_line || (!video_trigger_enable_n && video_trigger_in))) begin
         fired_nxt = 1'b1;
      end
   end

   always_comb begin
      rd_nxt = ram[addr_r];
   end

   // ---------------------------------------------
   // Registers
   // ---------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cw_r <= fapc_pkg::CW_RESET;
         hi_r <= 8'h00;
         held_r <= 8'h00;
         addr_r <= 15'h0000;
         post_r <= 16'h0000;
         rd_r <= 8'h00;
         hs_q_r <= 1'b0;
         ls_q_r <= 1'b0;
         fired_r <= 1'b0;
      end else begin
         cw_r <= cw_nxt;
         hi_r <= hi_nxt;
         held_r <= held_nxt;
         addr_r <= addr_nxt;
         post_r <= post_nxt;
         rd_r <= rd_nxt;
         hs_q_r <= high_byte_strobe;
         ls_q_r <= low_byte_strobe;
         fired_r <= fired_nxt;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (ram_we) begin
         ram[ram_wa] <= held_nxt;
      end
   end

   // ---------------------------------------------
   // Checks
   // ---------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   sequence s_load_tick;
      capture_run && sample_tick && !hold_load_n;
   endsequence
   sequence s_word_primary;
      hs_rise && !port_select_line ##[1:8] ls_rise && !port_select_line;
   endsequence

   a_full_rate_load: assert property (full_rate_select |-> !hold_load_n)
      else $error("full rate did not force load");
   a_sample_mode_load: assert property (!sample_mode_n |-> !hold_load_n)
      else $error("sample mode did not force load");
   a_bucket_start_load: assert property (bucket_start_clock |-> !hold_load_n)
      else $error("bucket start did not force load");
   a_peak_hold: assert property (!full_rate_select && sample_mode_n && !bucket_start_clock && !pit_select
      && adc_data <= held_r |-> hold_load_n)
      else $error("peak mode loaded a non-greater byte");
   a_pit_hold: assert property (!full_rate_select && sample_mode_n && !bucket_start_clock && pit_select
      && adc_data >= held_r |-> hold_load_n)
      else $error("pit mode loaded a non-smaller byte");
   a_latch_load: assert property (s_load_tick |=> held_r == $past(adc_data))
      else $error("hold latch missed a load");
   a_latch_keep: assert property (hold_load_n || !sample_tick || !capture_run |=> $stable(held_r))
      else $error("hold latch changed while not loading");
   a_cmp_code: assert property (!(input_below_held && input_above_held)
      && (adc_data == held_r) == (!input_below_held && !input_above_held))
      else $error("comparator code illegal");
   a_word_order: assert property (s_word_primary |=> cw_r == {$past(hi_r), $past(host_data_in)})
      else $error("control word not assembled high byte first");
   a_bus_release: assert property (host_data_oe |-> port_select_line && !capture_run)
      else $error("data bus driven outside secondary read");
   a_disarm_clear: assert property (!cw_r[fapc_pkg::CW_ARM] |=> !fired_r)
      else $error("trigger held while disarmed");
   a_fire_armed: assert property ($rose(fired_r) |-> $past(cw_r[fapc_pkg::CW_ARM]))
      else $error("trigger fired while disarmed");
   a_peak_load: assert property (!full_rate_select && sample_mode_n && !bucket_start_clock && !pit_select
      && adc_data > held_r |-> !hold_load_n)
      else $error("peak mode missed a greater byte");
   a_pit_load: assert property (!full_rate_select && sample_mode_n && !bucket_start_clock && pit_select
      && adc_data < held_r |-> !hold_load_n)
      else $error("pit mode missed a smaller byte");
   a_equal_hold: assert property (!full_rate_select && sample_mode_n && !bucket_start_clock
      && adc_data == held_r |-> hold_load_n)
      else $error("equal byte loaded the latch");

   // ---------------------------------------------
   // Checks on RAM write gate, counters and host port
   // ---------------------------------------------
   a_ram_gate: assert property (ram_we |-> capture_run && sample_tick && !ram_write_enable_n)
      else $error("sample RAM written while not enabled");
   a_run_no_read: assert property (capture_run |-> !host_data_oe)
      else $error("data bus driven during capture");
   a_bus_idle: assert property (!(high_byte_strobe || low_byte_strobe) |-> !host_data_oe)
      else $error("data bus driven without a strobe");
   a_read_dir: assert property (host_data_oe |-> sec_read)
      else $error("data bus driven outside read direction");
   a_addr_load: assert property (ls_rise && port_select_line && !sec_read && rd_clk_on && !addr_counter_load_n
      |=> addr_r == {$past(hi_r[6:0]), $past(host_data_in)})
      else $error("address counter load missed");
   a_post_load: assert property (ls_rise && port_select_line && !sec_read && rd_clk_on && !post_counter_load_n
      |=> post_r == {$past(hi_r), $past(host_data_in)})
      else $error("post counter load missed");
   a_read_incr: assert property (any_fall && port_select_line && sec_read && rd_clk_on
      |=> addr_r == 15'($past(addr_r) + 15'h0001))
      else $error("address not advanced after read");
   a_bucket_step: assert property (capture_run && sample_tick && bucket_start_clock
      |=> addr_r == 15'($past(addr_r) + 15'h0001))
      else $error("address not advanced at bucket start");
   a_full_step: assert property (capture_run && sample_tick && full_rate_select
      |=> addr_r == 15'($past(addr_r) + 15'h0001))
      else $error("address not advanced at full rate");
endmodule : fapc_capture
`default_nettype wire

/* verif/fapc_host_model.sv */
/*
 Host model for the capture block byte port.
 Assumes ref_clk from the bench; drives 2 ns after rising edges.
*/
`timescale 1ns/1ps
`default_nettype none
module fapc_host_model (
   input wire logic ref_clk,
   input wire logic host_data_oe,
   output logic port_select_line,
   output logic high_byte_strobe,
   output logic low_byte_strobe,
   output logic [7:0] host_drv
);
   initial begin
      port_select_line = 1'b0;
      high_byte_strobe = 1'b0;
      low_byte_strobe = 1'b0;
      host_drv = 8'h00;
   end
   // One strobed byte; released data shows its inverse
   task automatic xfer(input logic sel, input logic hi, input logic [7:0] b, output logic seen_oe);
      @(posedge ref_clk);
      #2;
      port_select_line = sel;
      host_drv = b;
      high_byte_strobe = hi;
      low_byte_strobe = ~hi;
      @(posedge ref_clk);
      seen_oe = host_data_oe;
      #2;
      high_byte_strobe = 1'b0;
      low_byte_strobe = 1'b0;
      host_drv = ~b;
   endtask : xfer
   task automatic write_word(input logic sel, input logic [15:0] w);
      logic s;
      xfer(sel, 1'b1, w[15:8], s);
      xfer(sel, 1'b0, w[7:0], s);
   endtask : write_word
endmodule : fapc_host_model
`default_nettype wire

/* verif/fapc_capture_tb.sv */
/*
 Self-checking bench for the capture block.
 Assumes the host model is compiled before this file.
*/
`timescale 1ns/1ps
`default_nettype none
module fapc_capture_tb;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] adc_data = 8'h00;
   logic sample_tick = 1'b0;
   logic bucket_start_clock = 1'b0;
   logic full_rate_select = 1'b0;
   logic sweep = 1'b0;
   logic sel, hs, ls, oe, hl_n, below, above, run, gain, vedge, smode_n, pit, fired;
   logic [7:0] drv, bus, dout, held;
   logic [15:0] cw, post;
   logic [14:0] addr;
   logic [15:0] mode_cw [4] = '{16'h03D5, 16'h83D9, 16'h03C1, 16'h03D1};
   logic [7:0] mode_exp [4] = '{8'h50, 8'h1E, 8'h3C, 8'h3C};
   logic [7:0] seq [4] = '{8'h32, 8'h50, 8'h1E, 8'h3C};
   logic [7:0] probe [3] = '{8'h3D, 8'h3B, 8'h3C};
   logic [15:0] rd_cw [3] = '{16'h01F0, 16'h03F0, 16'h03D1};
   int errors = 0;
   int checks_done = 0;
   always #12.5 ref_clk = ~ref_clk;
   assign bus = oe ? dout : drv;
   fapc_host_model host_u (.ref_clk(ref_clk), .host_data_oe(oe), .port_select_line(sel),
      .high_byte_strobe(hs), .low_byte_strobe(ls), .host_drv(drv));
   fapc_capture dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .adc_data(adc_data), .sample_tick(sample_tick),
      .bucket_start_clock(bucket_start_clock), .full_rate_select(full_rate_select),
      .sweep_trigger_line(sweep), .video_trigger_in(1'b0), .port_select_line(sel), .high_byte_strobe(hs),
      .low_byte_strobe(ls), .host_data_in(bus), .host_data_out(dout), .host_data_oe(oe), .hold_load_n(hl_n),
      .input_below_held(below), .input_above_held(above), .held_byte(held), .capture_run(run),
      .trigger_fired(fired), .double_gain_on(gain), .video_edge_select(vedge), .video_trigger_enable_n(),
      .sample_mode_n(smode_n), .ram_write_enable_n(), .addr_counter_load_n(), .post_counter_load_n(),
      .read_clock_enable_n(), .pit_select(pit), .capture_control_word(cw), .post_count_value(post),
      .ram_addr(addr));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic finish_test();
      if (errors == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : finish_test
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #2;
   endtask : wait_cyc
   task automatic set_cw(input logic [15:0] w);
      host_u.write_word(1'b0, w);
      wait_cyc(2);
   endtask : set_cw
   task automatic tick(input logic [7:0] b, input logic st);
      @(posedge ref_clk);
      #2;
      adc_data = b;
      sample_tick = 1'b1;
      bucket_start_clock = st;
      @(posedge ref_clk);
      #2;
      sample_tick = 1'b0;
   endtask : tick
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic check_modes();
      for (int m = 0; m < 4; m++) begin
         full_rate_select = (m == 3);
         set_cw(mode_cw[m]);
         for (int i = 0; i < 4; i++) begin
            tick(seq[i], i == 0);
         end
         chk(held, mode_exp[m]);
         chk(cw, mode_cw[m]);
         chk({run, gain, vedge, smode_n, pit}, {mode_cw[m][0], mode_cw[m][2], mode_cw[m][3], mode_cw[m][4],
            mode_cw[m][15]});
      end
   endtask : check_modes
   task automatic check_compare();
      full_rate_select = 1'b0;
      for (int k = 0; k < 3; k++) begin
         @(posedge ref_clk);
         #2;
         adc_data = probe[k];
         #1;
         chk({above, below, hl_n}, {k == 0, k == 1, k != 0});
      end
   endtask : check_compare
   task automatic check_host_reads();
      logic seen_oe;
      set_cw(16'h0130);
      host_u.write_word(1'b1, 16'h0105);
      wait_cyc(2);
      chk(addr, 16'h0105);
      chk(post, 16'h0105);
      for (int k = 0; k < 3; k++) begin
         set_cw(rd_cw[k]);
         host_u.xfer(1'b1, 1'b0, ~drv, seen_oe);
         wait_cyc(2);
         chk(seen_oe, k < 2);
         chk(addr, 16'h0106);
      end
   endtask : check_host_reads
   task automatic check_ram_read();
      tick(8'h77, 1'b1);
      bucket_start_clock = 1'b0;
      set_cw(16'h01F0);
      chk(dout, 8'h77);
      chk(addr, 16'h0107);
   endtask : check_ram_read
   task automatic check_trigger();
      set_cw(16'h03D3);
      sweep = 1'b1;
      wait_cyc(2);
      sweep = 1'b0;
      chk(fired, 1'b1);
      set_cw(16'h03D1);
      chk(fired, 1'b0);
      set_cw(16'h03D3);
      sweep = 1'b1;
      wait_cyc(2);
      sweep = 1'b0;
      rst_b = 1'b0;
      wait_cyc(2);
      rst_b = 1'b1;
      chk(cw, 16'h03F0);
      chk(fired, 1'b0);
   endtask : check_trigger
   initial begin
      repeat (6) @(posedge ref_clk);
      #2;
      rst_b = 1'b1;
      chk(cw, 16'h03F0);
      chk(oe, 1'b0);
      check_modes();
      check_compare();
      check_host_reads();
      check_ram_read();
      check_trigger();
      finish_test();
   end
   initial begin
      #1000000;
      errors++;
      finish_test();
   end
endmodule : fapc_capture_tb
`default_nettype wire
